/* pkg/bound_pkg.sv */
/*
 * shared constants for the frame period bound register group and its controller.
 * assumes a 10 MHz clock on both ends and a byte-wide register port between them.
 */
package bound_pkg;
   // register offsets on the byte port
   localparam logic [6:0] FW_COMMAND_ADDR   = 7'h14;
   localparam logic [6:0] CEIL_LOW_ADDR     = 7'h19;
   localparam logic [6:0] CEIL_HIGH_ADDR    = 7'h1a;
   localparam logic [6:0] FLOOR_LOW_ADDR    = 7'h1b;
   localparam logic [6:0] FLOOR_HIGH_ADDR   = 7'h1c;
   localparam logic [6:0] EXPO_LOW_ADDR     = 7'h1d;
   localparam logic [6:0] LOAD_PORT_ADDR    = 7'h60;
   // reset values, plus the floor upper byte after download and the fixed exposure upper byte
   localparam logic [7:0] FW_COMMAND_RESET  = 8'h00;
   localparam logic [7:0] CEIL_LOW_RESET    = 8'he0;
   localparam logic [7:0] CEIL_HIGH_RESET   = 8'h2e;
   localparam logic [7:0] FLOOR_LOW_RESET   = 8'hac;
   localparam logic [7:0] FLOOR_HIGH_RESET  = 8'h0d;
   localparam logic [7:0] FLOOR_HIGH_LOADED = 8'h0e;
   localparam logic [7:0] EXPO_LOW_RESET    = 8'h8c;
   localparam logic [7:0] EXPO_HIGH_FIXED   = 8'h20;
   // firmware commands
   localparam logic [7:0] CMD_DOWNLOAD      = 8'h18;
   localparam logic [7:0] CMD_SELFTEST      = 8'ha1;
   // floor write range
   localparam logic [15:0] FLOOR_MIN_WRITE  = 16'h7e0e;
   localparam logic [15:0] FLOOR_MAX_WRITE  = 16'hffff;
   // timing
   localparam int CLOCK_HZ        = 10_000_000;
   localparam int SELFTEST_US     = 7000;
   localparam int SELFTEST_CYCLES = (SELFTEST_US * (CLOCK_HZ / 1_000_000));
   localparam int APPLY_FRAMES    = 2;
   // controller wishbone offsets (byte addresses)
   localparam logic [3:0] HOST_BYTE_OP      = 4'h0;
   localparam logic [3:0] HOST_PAIR_OP      = 4'h4;
   localparam logic [3:0] HOST_CONTROL      = 4'h8;
   localparam logic [3:0] HOST_STATUS       = 4'hc;
   // controller field positions and the auto bit reset value
   localparam int BYTE_ADDR_LSB  = 8;
   localparam int BYTE_WE_BIT    = 16;
   localparam int PAIR_SEL_LSB   = 16;
   localparam int PAIR_WE_BIT    = 20;
   localparam int CTRL_AUTO_BIT  = 0;
   localparam int STAT_DATA_LSB  = 16;
   localparam logic CTRL_AUTO_RESET = 1'b1;
endpackage

/* pkg/bound_if.sv */
/*
 * byte register port joining the controller and the sensor register group.
 * assumes both ends share clk; the controller holds a request until ack.
 */
`timescale 1ns/1ps
interface bound_if;
   logic       req;          // request held until ack
   logic       we;           // write when high
   logic [6:0] addr;         // register offset
   logic [7:0] wdata;        // write byte
   logic [7:0] rdata;        // read byte, valid with ack
   logic       ack;          // one-cycle answer
   logic       auto_mode;    // automatic frame rate enable
   logic       bounds_busy;  // bounds still being applied
   logic       selftest_busy;// checksum test running

   modport sensor (input req, we, addr, wdata, auto_mode,
                   output rdata, ack, bounds_busy, selftest_busy);
   modport controller (output req, we, addr, wdata, auto_mode,
                       input rdata, ack, bounds_busy, selftest_busy);
endinterface // bound_if

/* verilog/bound_sensor.sv */
/*
 * sensor end: staged and active frame period bounds, firmware command,
 * frame timer and checksum self-test timing.
 * assumes a controller on bound_if that holds each request until ack.
 */
// Added by the designer: the Wishbone interface to the registers.
`timescale 1ns/1ps
module bound_sensor #(
   parameter int SELFTEST_LEN = bound_pkg::SELFTEST_CYCLES
) (
   input  wire logic        clk_i,
   input  wire logic        rst_i,
   bound_if.sensor          bus,
   input  wire logic [15:0] exposure_req_i,
   output logic             frame_tick_o,
   output logic [15:0]      frame_period_o,
   output logic [15:0]      exposure_o,
   output logic             tracking_o,
   output logic             fw_ready_o,
   output logic             download_fail_o
);
   import bound_pkg::*;

   // staged copies, read back by software
   logic [7:0]  ceil_lo, ceil_hi, floor_lo, floor_hi, expo_lo;
   // active copies, steer the frame timer
   logic [15:0] act_ceil, act_floor, act_expo;
   logic [7:0]  fw_cmd;
   logic [15:0] frame_cnt;
   logic [1:0]  apply_left;
   logic [31:0] st_cnt;
   logic        st_wait_frame;
   logic        wr, rd_req;
   logic [15:0] next_period;
   logic [15:0] limited_expo;

   function automatic logic [15:0] umin(input logic [15:0] a, input logic [15:0] b);
      return (a < b) ? a : b;
   endfunction

   function automatic logic [15:0] umax(input logic [15:0] a, input logic [15:0] b);
      return (a > b) ? a : b;
   endfunction

   assign wr     = bus.req & bus.we & ~bus.ack;
   assign rd_req = bus.req & ~bus.we & ~bus.ack;

   // one-cycle answer; the controller holds the request so ack falls next cycle
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         bus.ack <= 1'b0;
      end else begin
         bus.ack <= bus.req & ~bus.ack;
      end
   end

   // read data returns staged values, not the active ones
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         bus.rdata <= 8'h00;
      end else if (rd_req) begin
         case (bus.addr)
            CEIL_LOW_ADDR:   bus.rdata <= ceil_lo;
            CEIL_HIGH_ADDR:  bus.rdata <= ceil_hi;
            FLOOR_LOW_ADDR:  bus.rdata <= floor_lo;
            FLOOR_HIGH_ADDR: bus.rdata <= floor_hi;
            EXPO_LOW_ADDR:   bus.rdata <= expo_lo;
            default:         bus.rdata <= 8'h00;     // command is write-only
         endcase
      end
   end

   // firmware command register, kept internally for the download check
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         fw_cmd <= FW_COMMAND_RESET;
      end else if (wr && bus.addr == FW_COMMAND_ADDR) begin
         fw_cmd <= bus.wdata;
      end
   end

   // a load-port write succeeds only with the download command in place
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         fw_ready_o      <= 1'b0;
         download_fail_o <= 1'b0;
      end else if (wr && bus.addr == LOAD_PORT_ADDR) begin
         fw_ready_o      <= (fw_cmd == CMD_DOWNLOAD) | fw_ready_o;
         download_fail_o <= (fw_cmd != CMD_DOWNLOAD);
      end
   end

   // staged registers: plain byte stores, floor upper follows firmware state
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         ceil_lo  <= CEIL_LOW_RESET;
         ceil_hi  <= CEIL_HIGH_RESET;
         floor_lo <= FLOOR_LOW_RESET;
         floor_hi <= FLOOR_HIGH_RESET;
         expo_lo  <= EXPO_LOW_RESET;
      end else if (wr) begin
         case (bus.addr)
            CEIL_LOW_ADDR:   ceil_lo  <= bus.wdata;
            CEIL_HIGH_ADDR:  ceil_hi  <= bus.wdata;
            FLOOR_LOW_ADDR:  floor_lo <= bus.wdata;
            FLOOR_HIGH_ADDR: floor_hi <= bus.wdata;
            EXPO_LOW_ADDR:   expo_lo  <= bus.wdata;
            LOAD_PORT_ADDR: begin
               // a good download moves the untouched floor default up
               if (fw_cmd == CMD_DOWNLOAD && !fw_ready_o &&
                   floor_hi == FLOOR_HIGH_RESET) begin
                  floor_hi <= FLOOR_HIGH_LOADED;
               end
            end
            default: ;
         endcase
      end
   end

   // the upper ceiling write completes the pair and copies all staged bounds
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         act_ceil  <= {CEIL_HIGH_RESET, CEIL_LOW_RESET};
         act_floor <= {FLOOR_HIGH_RESET, FLOOR_LOW_RESET};
         act_expo  <= {EXPO_HIGH_FIXED, EXPO_LOW_RESET};
      end else if (wr && bus.addr == CEIL_HIGH_ADDR) begin
         act_ceil  <= {bus.wdata, ceil_lo};
         act_floor <= {floor_hi, floor_lo};
         act_expo  <= {EXPO_HIGH_FIXED, expo_lo};
      end else if (wr && bus.addr == LOAD_PORT_ADDR && fw_cmd == CMD_DOWNLOAD &&
                   !fw_ready_o && floor_hi == FLOOR_HIGH_RESET) begin
         act_floor <= {FLOOR_HIGH_LOADED, act_floor[7:0]};
      end
   end

   // busy until two whole frames follow the activating write; the tick that
   // ends the frame already running is only a partial frame, so it adds one
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         apply_left <= 2'd0;
      end else if (wr && bus.addr == CEIL_HIGH_ADDR) begin
         apply_left <= 2'(APPLY_FRAMES + 1);
      end else if (frame_tick_o && apply_left != 2'd0) begin
         apply_left <= apply_left - 2'd1;
      end
   end
   assign bus.bounds_busy = (apply_left != 2'd0);

   // exposure limit; manual mode uses the ceiling value itself
   assign limited_expo = bus.auto_mode ? umin(exposure_req_i, act_expo)
                                       : act_expo;

   // period: manual takes the ceiling, automatic picks floor plus exposure
   // clamped into [floor, ceiling]
   always_comb begin
      if (bus.auto_mode) begin
         next_period = umin(act_ceil,
                            umax(act_floor,
                                 16'(act_floor + limited_expo)));
      end else begin
         next_period = act_ceil;
      end
      if (next_period == 16'h0000) begin
         next_period = 16'h0001;   // a zero period would stall the timer
      end
   end

   // frame timer: one tick every period cycles, so rate = clock / period
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         frame_cnt    <= 16'h0000;
         frame_tick_o <= 1'b0;
      end else if (frame_cnt >= 16'(next_period - 16'h0001)) begin
         frame_cnt    <= 16'h0000;
         frame_tick_o <= 1'b1;
      end else begin
         frame_cnt    <= frame_cnt + 16'h0001;
         frame_tick_o <= 1'b0;
      end
   end

   // period and exposure in use, latched at each frame boundary
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         frame_period_o <= {CEIL_HIGH_RESET, CEIL_LOW_RESET};
         exposure_o     <= 16'h0000;
      end else if (frame_tick_o) begin
         frame_period_o <= next_period;
         exposure_o     <= limited_expo;
      end
   end

   // checksum test: fixed time, then wait out one more frame boundary
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         st_cnt        <= 32'd0;
         st_wait_frame <= 1'b0;
      end else if (wr && bus.addr == FW_COMMAND_ADDR && bus.wdata == CMD_SELFTEST) begin
         st_cnt        <= 32'(SELFTEST_LEN);
         st_wait_frame <= 1'b0;
      end else if (st_cnt != 32'd0) begin
         st_cnt        <= st_cnt - 32'd1;
         st_wait_frame <= (st_cnt == 32'd1);
      end else if (st_wait_frame && frame_tick_o) begin
         st_wait_frame <= 1'b0;
      end
   end
   assign bus.selftest_busy = (st_cnt != 32'd0) | st_wait_frame;
   assign tracking_o        = ~bus.selftest_busy;

endmodule // bound_sensor

/* verilog/bound_controller.sv */
/*
 * controller end: wishbone classic slave that turns software orders into
 * byte transfers on bound_if, with pair ordering and write guards.
 * assumes the sensor answers each request with a one-cycle ack.
 */
`timescale 1ns/1ps
module bound_controller #(
   parameter int SELFTEST_LEN = bound_pkg::SELFTEST_CYCLES
) (
   input  wire logic        clk_i,
   input  wire logic        rst_i,
   input  wire logic        cyc_i,
   input  wire logic        stb_i,
   input  wire logic        we_i,
   input  wire logic [3:0]  adr_i,
   input  wire logic [3:0]  sel_i,
   input  wire logic [31:0] dat_i,
   output logic [31:0]      dat_o,
   output logic             ack_o,
   bound_if.controller      bus
);
   import bound_pkg::*;

   typedef enum logic [1:0] {IDLE, ISSUE, WAIT_ACK, HOLD} state_t;
   state_t      state;
   logic [6:0]  op_addr [2];
   logic [7:0]  op_data [2];
   logic        op_we;
   logic        op_idx, op_last;
   logic [15:0] rd_pair;
   logic        refused;
   logic [15:0] last_ceil, last_floor, last_expo;
   logic [31:0] hold_cnt;
   logic        wb_wr;
   logic [6:0]  pair_base;
   logic [15:0] pv;

   assign wb_wr = cyc_i & stb_i & we_i & ~ack_o & (sel_i != 4'h0);
   assign pv    = dat_i[15:0];

   always_comb begin
      case (dat_i[PAIR_SEL_LSB +: 2])
         2'd0:    pair_base = CEIL_LOW_ADDR;
         2'd1:    pair_base = FLOOR_LOW_ADDR;
         default: pair_base = EXPO_LOW_ADDR;
      endcase
   end

   // wishbone ack one cycle after the strobe, dropped the cycle after
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         ack_o <= 1'b0;
      end else begin
         ack_o <= cyc_i & stb_i & ~ack_o;
      end
   end

   // status and read data
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         dat_o <= 32'h0;
      end else if (cyc_i && stb_i && !we_i && !ack_o) begin
         dat_o <= 32'h0;
         if (adr_i == HOST_STATUS) begin
            dat_o <= {rd_pair, 12'h0, bus.selftest_busy, bus.bounds_busy,
                      refused, (state != IDLE)};
         end else if (adr_i == HOST_CONTROL) begin
            dat_o <= {31'h0, bus.auto_mode};
         end
      end
   end

   // automatic mode bit; software clears it before a manual ceiling write
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         bus.auto_mode <= CTRL_AUTO_RESET;
      end else if (wb_wr && adr_i == HOST_CONTROL) begin
         bus.auto_mode <= dat_i[CTRL_AUTO_BIT];
      end
   end

   // order intake and byte sequencing; orders arriving outside IDLE are dropped, refused marks guarded pair writes
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         state      <= IDLE;
         op_we      <= 1'b0;
         op_idx     <= 1'b0;
         op_last    <= 1'b0;
         refused    <= 1'b0;
         rd_pair    <= 16'h0;
         hold_cnt   <= 32'd0;
         op_addr[0] <= 7'h0;
         op_addr[1] <= 7'h0;
         op_data[0] <= 8'h0;
         op_data[1] <= 8'h0;
         last_ceil  <= {CEIL_HIGH_RESET, CEIL_LOW_RESET};
         last_floor <= {FLOOR_HIGH_RESET, FLOOR_LOW_RESET};
         last_expo  <= {EXPO_HIGH_FIXED, EXPO_LOW_RESET};
         bus.req    <= 1'b0;
         bus.we     <= 1'b0;
         bus.addr   <= 7'h0;
         bus.wdata  <= 8'h0;
      end else begin
         case (state)
            IDLE: begin
               if (wb_wr && adr_i == HOST_BYTE_OP) begin
                  op_addr[0] <= dat_i[BYTE_ADDR_LSB +: 7];
                  op_data[0] <= dat_i[7:0];
                  op_we      <= dat_i[BYTE_WE_BIT];
                  op_idx     <= 1'b0;
                  op_last    <= 1'b0;
                  refused    <= 1'b0;
                  state      <= ISSUE;
               end else if (wb_wr && adr_i == HOST_PAIR_OP) begin
                  if (dat_i[PAIR_WE_BIT]) begin
                     if (bus.bounds_busy ||
                         (pair_base == FLOOR_LOW_ADDR && pv < FLOOR_MIN_WRITE) ||
                         (pair_base == CEIL_LOW_ADDR &&
                          17'(pv) < 17'(last_floor) + 17'(last_expo))) begin
                        refused <= 1'b1;
                     end else begin
                        op_addr[0] <= pair_base;
                        op_addr[1] <= 7'(pair_base + 7'h1);
                        op_data[0] <= pv[7:0];
                        op_data[1] <= pv[15:8];
                        op_we      <= 1'b1;
                        op_idx     <= 1'b0;
                        op_last    <= 1'b1;
                        refused    <= 1'b0;
                        state      <= ISSUE;
                        case (pair_base)
                           CEIL_LOW_ADDR:  last_ceil  <= pv;
                           FLOOR_LOW_ADDR: last_floor <= pv;
                           default:        last_expo  <= {EXPO_HIGH_FIXED, pv[7:0]};
                        endcase
                     end
                  end else begin
                     op_addr[0] <= (pair_base == EXPO_LOW_ADDR) ? pair_base
                                   : 7'(pair_base + 7'h1);
                     op_addr[1] <= pair_base;
                     op_we      <= 1'b0;
                     op_idx     <= 1'b0;
                     op_last    <= (pair_base != EXPO_LOW_ADDR);
                     refused    <= 1'b0;
                     state      <= ISSUE;
                  end
               end
            end
            ISSUE: begin
               bus.req   <= 1'b1;
               bus.we    <= op_we;
               bus.addr  <= op_addr[op_idx];
               bus.wdata <= op_data[op_idx];
               state     <= WAIT_ACK;
            end
            WAIT_ACK: begin
               if (bus.ack) begin
                  bus.req <= 1'b0;
                  if (!op_we) begin
                     rd_pair <= op_last ? {rd_pair[7:0], bus.rdata}
                                        : {8'h00, bus.rdata};
                  end
                  if (op_idx != op_last) begin
                     op_idx <= 1'b1;                                 // back to back
                     state  <= ISSUE;
                  end else if (op_we && bus.addr == FW_COMMAND_ADDR &&
                               bus.wdata == CMD_SELFTEST) begin
                     // no traffic for 7 ms plus the longest frame
                     hold_cnt <= 32'(SELFTEST_LEN) + 32'(last_ceil);
                     state    <= HOLD;
                  end else begin
                     state <= IDLE;
                  end
               end
            end
            HOLD: begin
               if (hold_cnt == 32'd0) begin
                  state <= IDLE;
               end else begin
                  hold_cnt <= hold_cnt - 32'd1;
               end
            end
            default: state <= IDLE;
         endcase
      end
   end

endmodule // bound_controller

/* tb/bound_checker.sv */
/*
 * concurrent checks on the byte register port between controller and sensor.
 * assumes one clock and a synchronous active-high reset shared by both ends.
 */
`timescale 1ns/1ps
module bound_checker #(
   parameter int SELFTEST_LEN = bound_pkg::SELFTEST_CYCLES
) (
   input wire logic       clk_i,
   input wire logic       rst_i,
   input wire logic       req,
   input wire logic       we,
   input wire logic [6:0] addr,
   input wire logic [7:0] wdata,
   input wire logic [7:0] rdata,
   input wire logic       ack,
   input wire logic       bounds_busy,
   input wire logic       selftest_busy
);
   import bound_pkg::*;
   logic [6:0] last_wr;
   logic [6:0] last_any;
   logic [7:0] shadow [8];
   logic [7:0] seen;
   int         hold;
   wire        take  = req && !ack;
   wire        bnd   = (addr >= CEIL_LOW_ADDR) && (addr <= EXPO_LOW_ADDR);
   wire  [2:0] idx   = 3'(addr - CEIL_LOW_ADDR);
   wire        st_go = ack && we && addr == FW_COMMAND_ADDR && wdata == CMD_SELFTEST;

   default clocking @(posedge clk_i); endclocking
   default disable iff (rst_i);

   // last offsets taken, so the byte order of pairs can be judged
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         last_wr  <= '0;
         last_any <= '0;
      end else if (take) begin
         last_any <= addr;
         if (we) last_wr <= addr;
      end
   end

   // staged bytes as written; reads must give them back before activation too
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         seen <= '0;
      end else if (take && we && bnd) begin
         seen[idx]   <= 1'b1;
         shadow[idx] <= wdata;
      end
   end

   // quiet span after a self-test start
   always_ff @(posedge clk_i) begin
      if (rst_i) hold <= 0;
      else if (st_go) hold <= SELFTEST_LEN;
      else if (hold > 0) hold <= hold - 1;
   end

   a_ack_pulse: assert property (take |=> ack ##1 !ack)
      else $error("ack is not a one-cycle answer");
   a_req_held: assert property (take |=> req && $stable(addr) &&
      $stable(we) && $stable(wdata))
      else $error("request changed before ack");
   a_write_order: assert property (take && we && (addr == CEIL_HIGH_ADDR ||
      addr == FLOOR_HIGH_ADDR) |-> last_wr == addr - 7'h1)
      else $error("upper byte written before lower byte");
   a_read_order: assert property (take && !we && (addr == CEIL_LOW_ADDR ||
      addr == FLOOR_LOW_ADDR) |-> last_any == addr + 7'h1)
      else $error("lower byte read without upper byte first");
   a_busy_rise: assert property (ack && we && addr == CEIL_HIGH_ADDR |->
      ##[1:3] bounds_busy)
      else $error("activation did not raise busy");
   a_no_bound_wr: assert property (bounds_busy |-> !(take && we && bnd))
      else $error("bound written while bounds are applied");
   a_read_back: assert property (ack && !we && bnd && seen[idx] |-> rdata == shadow[idx])
      else $error("bound read differs from last write");
   a_st_start: assert property (st_go |-> ##[0:2] selftest_busy)
      else $error("self-test did not start");
   a_st_quiet: assert property (req |-> hold == 0)
      else $error("port used during self-test");
endmodule // bound_checker

/* tb/tb_top.sv */
/*
 * self-checking bench: controller and sensor joined by bound_if, driven over wishbone.
 * assumes the package and interface are compiled first; 10 MHz clock.
 */
`timescale 1ns/1ps
module tb_top;
   import bound_pkg::*;
   typedef struct packed {logic [15:0] req; logic [15:0] expo; logic [15:0] per;} row_t;
   localparam int ST_LEN = 50;
   logic        clk_i       = 1'b0;
   logic        rst_i       = 1'b1;
   logic        cyc         = 1'b0;
   logic        stb         = 1'b0;
   logic        wen         = 1'b0;
   logic [3:0]  adr         = 4'h0;
   logic [3:0]  sel         = 4'h0;
   logic [31:0] dat         = 32'h0;
   logic [15:0] expo_req    = 16'h0000;
   logic [31:0] dat_o;
   logic        ack_o;
   logic        tick;
   logic [15:0] period;
   logic [15:0] expo;
   logic        tracking;
   logic        fw_ready;
   logic        dl_fail;
   logic [31:0] q;
   int          miscompares = 0;
   int          n_tests     = 0;
   int          n;
   // auto rate cases: wanted exposure, exposure used, period used
   row_t        rows [3]    = '{'{16'h0000, 16'h0000, 16'h0dac},
                                '{16'h0100, 16'h0100, 16'h0eac},
                                '{16'hffff, 16'h2000, 16'h2dac}};

   bound_if link ();
   bound_sensor #(.SELFTEST_LEN(ST_LEN)) u_bound_sensor (.clk_i(clk_i), .rst_i(rst_i),
      .bus(link), .exposure_req_i(expo_req), .frame_tick_o(tick), .frame_period_o(period),
      .exposure_o(expo), .tracking_o(tracking), .fw_ready_o(fw_ready),
      .download_fail_o(dl_fail));
   bound_controller #(.SELFTEST_LEN(ST_LEN)) u_bound_controller (.clk_i(clk_i),
      .rst_i(rst_i), .cyc_i(cyc), .stb_i(stb), .we_i(wen), .adr_i(adr), .sel_i(sel),
      .dat_i(dat), .dat_o(dat_o), .ack_o(ack_o), .bus(link));
   bound_checker #(.SELFTEST_LEN(ST_LEN)) u_bound_checker (.clk_i(clk_i), .rst_i(rst_i),
      .req(link.req), .we(link.we), .addr(link.addr), .wdata(link.wdata),
      .rdata(link.rdata), .ack(link.ack), .bounds_busy(link.bounds_busy),
      .selftest_busy(link.selftest_busy));

   always #50 clk_i = ~clk_i;

   task automatic chk(input string nm, input logic [15:0] e, input logic [15:0] g);
      n_tests++;
      if (g !== e) begin
         miscompares++;
         $display("MISMATCH %s expected %h seen %h", nm, e, g);
      end
   endtask

   // one classic cycle, held until ack is sampled high; one idle cycle after
   task automatic wb(input logic [3:0] a, input logic w, input logic [31:0] d);
      int k;
      k = 0;
      cyc <= 1'b1;
      stb <= 1'b1;
      wen <= w;
      adr <= a;
      sel <= 4'hf;
      dat <= d;
      do begin
         @(posedge clk_i);
         k++;
      end while (ack_o !== 1'b1 && k < 50);
      if (ack_o !== 1'b1) begin
         miscompares++;
         $display("MISMATCH wb ack expected 1 seen %b", ack_o);
      end
      q = dat_o;
      cyc <= 1'b0;
      stb <= 1'b0;
      @(posedge clk_i);
   endtask

   // poll status until the masked bits are clear
   task automatic idle(input logic [31:0] m);
      int k;
      k = 0;
      do begin
         wb(HOST_STATUS, 1'b0, 32'h0);
         k++;
      end while ((q & m) != 32'h0 && k < 20000);
      if ((q & m) != 32'h0) begin
         miscompares++;
         $display("MISMATCH idle status expected 0 seen %h", q & m);
      end
   endtask

   task automatic byte_op(input logic w, input logic [6:0] a, input logic [7:0] v);
      idle(32'h1);
      wb(HOST_BYTE_OP, 1'b1, {15'h0, w, 1'b0, a, v});
      idle(32'h1);
   endtask

   // a read leaves the value in q[31:16]
   task automatic pair(input logic w, input logic [1:0] s, input logic [15:0] v);
      idle(32'h1);
      wb(HOST_PAIR_OP, 1'b1, {11'h0, w, 2'h0, s, v});
      idle(32'h1);
   endtask

   // n ends as the cycle count since the previous tick
   task automatic wait_tick();
      n = 0;
      do begin
         @(posedge clk_i);
         n++;
      end while (tick !== 1'b1 && n < 70000);
      if (tick !== 1'b1) begin
         miscompares++;
         $display("MISMATCH frame tick expected 1 seen %b", tick);
      end
   endtask

   task automatic stop_test();
      $display("comparisons %0d mismatches %0d", n_tests, miscompares);
      if (miscompares == 0 && n_tests > 0)
         $display("Run complete: PASS");
      else
         $display("Run complete: FAIL");
      $finish;
   endtask

   // watchdog: the longest frames add up to about 87000 cycles
   initial begin
      repeat (99000) @(posedge clk_i);
      miscompares++;
      stop_test();
   end

   initial begin
      repeat (4) @(posedge clk_i);
      rst_i <= 1'b0;
      pair(1'b0, 2'd0, 16'h0);
      chk("ceiling", 16'h2ee0, q[31:16]);
      pair(1'b0, 2'd1, 16'h0);
      chk("floor", 16'h0dac, q[31:16]);
      pair(1'b0, 2'd2, 16'h0);
      chk("exposure low", 16'h008c, {8'h0, q[23:16]});
      byte_op(1'b0, 7'h15, 8'h00);
      chk("reserved", 16'h0000, {8'h0, q[23:16]});
      wb(HOST_CONTROL, 1'b0, 32'h0);
      chk("auto mode", 16'h1, {15'h0, q[0]});
      chk("reset period", 16'h2ee0, period);
      $display("reset values done");
      pair(1'b1, 2'd2, 16'h0000);
      pair(1'b1, 2'd0, 16'h3000);
      chk("bounds busy", 16'h1, {15'h0, q[2]});
      idle(32'h5);
      pair(1'b1, 2'd2, 16'h0040);
      pair(1'b0, 2'd2, 16'h0);
      chk("staged exposure", 16'h0040, {8'h0, q[23:16]});
      pair(1'b0, 2'd0, 16'h0);
      chk("ceiling", 16'h3000, q[31:16]);
      $display("staging done");
      // last row: staged exposure ceiling must not be in force yet
      foreach (rows[i]) begin
         expo_req <= rows[i].req;
         wait_tick();
         wait_tick();
         chk("exposure", rows[i].expo, expo);
         chk("period", rows[i].per, period);
         chk("frame length", rows[i].per, 16'(n));
      end
      $display("auto rate rows done");
      pair(1'b1, 2'd0, 16'h1000);
      chk("refused", 16'h1, {15'h0, q[1]});
      pair(1'b1, 2'd1, 16'h7e0d);
      chk("floor refused", 16'h1, {15'h0, q[1]});
      pair(1'b0, 2'd0, 16'h0);
      chk("ceiling kept", 16'h3000, q[31:16]);
      wb(HOST_CONTROL, 1'b1, 32'h0);
      wait_tick();
      wait_tick();
      chk("manual period", 16'h3000, period);
      chk("manual length", 16'h3000, 16'(n));
      $display("refusal and manual rate done");
      byte_op(1'b1, LOAD_PORT_ADDR, 8'h5a);
      chk("load rejected", 16'h1, {15'h0, dl_fail});
      byte_op(1'b1, FW_COMMAND_ADDR, CMD_DOWNLOAD);
      byte_op(1'b1, LOAD_PORT_ADDR, 8'h5a);
      chk("fw ready", 16'h1, {15'h0, fw_ready});
      chk("load ok", 16'h0, {15'h0, dl_fail});
      pair(1'b0, 2'd1, 16'h0);
      chk("floor loaded", 16'h0eac, q[31:16]);
      $display("download done");
      idle(32'h1);
      wb(HOST_BYTE_OP, 1'b1, {15'h0, 1'b1, 1'b0, FW_COMMAND_ADDR, CMD_SELFTEST});
      n = 0;
      do begin
         wb(HOST_STATUS, 1'b0, 32'h0);
         n++;
      end while (q[3] !== 1'b1 && n < 20);
      chk("tracking halted", 16'h0, {15'h0, tracking});
      idle(32'h9);
      chk("tracking back", 16'h1, {15'h0, tracking});
      $display("self-test done");
      rst_i <= 1'b1;
      repeat (4) @(posedge clk_i);
      rst_i <= 1'b0;
      pair(1'b0, 2'd0, 16'h0);
      chk("ceiling again", 16'h2ee0, q[31:16]);
      chk("fw cleared", 16'h0, {15'h0, fw_ready});
      $display("second reset done");
      stop_test();
   end
endmodule // tb_top
